/* File: fp_regs_defs.svh */
// Index, field and reset constants for the flat panel control register bank
`ifndef FP_REGS_DEFS_SVH
`define FP_REGS_DEFS_SVH
// Register indices
`define IDX_PANEL_CONTROL_TWO 8'h33
`define IDX_PANEL_UNLOCK_KEY 8'h34
`define IDX_MAP_UNLOCK_KEY 8'h35
`define IDX_MAP_ADDR_COUNTER 8'h38
`define IDX_MAP_DATA_PORT 8'h39
`define IDX_MAP_PD_CONTROL 8'h3A
`define IDX_PANEL_HEIGHT 8'h3B
`define IDX_PANEL_BLINK 8'h3C
`define IDX_COLOR_LCD 8'h3E
`define IDX_PD_REFRESH 8'h3F
// Unlock patterns
`define PANEL_KEY_PATTERN 3'h5
`define SHADOW_KEY_PATTERN 3'h6
`define MAP_KEY_VALUE 8'h30
// Field positions
`define PC2_SHADING 2
`define PC2_REFRESH_TWO 1
`define PC2_REFRESH_SRC 0
`define MPD_SYS_POWERDOWN 7
`define MPD_DIV8 6
`define MPD_HOST_RELEASE 5
`define MPD_MAP_BYPASS 3
`define MPD_WEIGHTING 1
`define MPD_WRITE_MASK 8'hEA
`define BLK_LP_FREE_RUN 7
`define BLK_SCLK_POL 6
`define CLC_CRT_SYNC 2
`define CLC_FP_POL 1
`define CLC_LP_POL 0
`define PDR_GENERAL_PD 7
// Reset values
`define RST_BYTE 8'h00
// Clock divider for general powerdown
`define PD_DIV_RATIO 3'h7
// Blink: code 1 toggles on frame counter bit 3 (8 frames)
`define BLINK_BIT_OFFSET 3'h2
`define BLINK_CODE_MAX 3'h5
`endif

/* File: fp_regs_pkg.sv */
// Types shared by the flat panel control register bank
package fp_regs_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [2:0] blink_code_t;
endpackage

/* File: flat_panel_control_regs.sv */
// Indexed flat panel control register bank with mapping RAM and blink logic
//
// Notes on behaviour
// - Shading bit 0 selects frame rate modulation (reset), 1 pulse width.
// - Refresh-count bit gives one refresh per line at 0, two at 1 when the refresh source bit is 1.
// - Refresh source bit 0 leaves refresh to CRT controller, 1 uses count.
// - Key 101XXXX at 34h opens panel registers until another value written.
// - Key low bits 110 at 34h unlock shadow registers until rewritten.
// - Mapping registers open only after 30h in mapping unlock register.
// - Each data port read or write advances the address counter by one.
// - Power-down bit 7: 0 idle mode, 1 system power-down, stopping clocks only with general powerdown enabled.
// - Divide-by-8 select acts only with general powerdown enabled.
// - Host release with powerdown input low ignores host and tristates.
// - Bypass bit 0 uses mapping RAM, 1 applies direct 1:1 mapping.
// - Weighting bit enables 0.3R 0.59G 0.11B luminance in all modes.
// - Blinking control has no effect on output in CRT mode.
// - Latch select 0 stops latch pulses in vblank, 1 free-runs, shift stopped.
// - Shift polarity 0 data on rising edge, 1 on falling edge.
// - Character blink codes 0-5: off, 8/16/32/64/128 frames on and off.
// - Cursor blink field uses the same encoding.
// - CRT sync enable 0 (reset) holds syncs high, 1 passes CRT sync.
// - Frame pulse polarity 0 normal, 1 inverted.
`include "fp_regs_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module flat_panel_control_regs
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Indexed host port
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_index,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic io_rdata_oe,
   output logic sys_bus_oe,
   // Pins
   input wire logic powerdown_input,
   // Timing inputs from panel and CRT logic
   input wire logic frame_tick,
   input wire logic crt_mode,
   input wire logic vblank,
   input wire logic crt_vsync,
   input wire logic crt_hsync,
   input wire logic frame_start_raw,
   input wire logic line_latch_raw,
   // Mapping RAM lookup
   input wire logic [7:0] shade_index,
   output logic [7:0] shade_value,
   // Control fields
   output logic shading_pwm,
   output logic refresh_by_count,
   output logic refresh_two_per_line,
   output logic panel_unlocked,
   output logic shadow_unlocked,
   output logic sys_powerdown_mode,
   output logic clocks_stopped,
   output logic pd_div8_tick,
   output logic mapping_bypass,
   output logic weighting_enable,
   output logic [7:0] panel_height,
   output logic shift_clk_polarity,
   output logic shift_clk_stop,
   output logic char_blink_on,
   output logic cursor_blink_on,
   // Panel and CRT pins
   output logic line_latch_pulse,
   output logic frame_start_pulse,
   output logic vsync_out,
   output logic hsync_out
);
   ////////////////////////////////////////////////////////////////
   // Storage
   fp_regs_pkg::byte_t pc2_reg;
   fp_regs_pkg::byte_t map_key_reg;
   fp_regs_pkg::byte_t map_addr_reg;
   fp_regs_pkg::byte_t mpd_reg;
   fp_regs_pkg::byte_t height_reg;
   fp_regs_pkg::byte_t blink_reg;
   fp_regs_pkg::byte_t clc_reg;
   fp_regs_pkg::byte_t pdr_reg;
   fp_regs_pkg::byte_t map_ram [0:255];
   fp_regs_pkg::byte_t frame_cnt_reg;
   logic panel_open_reg;
   logic shadow_open_reg;
   logic pd_meta_reg;
   logic pd_sync_reg;
   logic [2:0] div_cnt_reg;

   // Blink phase from code; code 0 or illegal gives steady on
   function automatic logic blink_phase(input fp_regs_pkg::blink_code_t code,
                                        input fp_regs_pkg::byte_t cnt);
      logic [2:0] pos;
      pos = code + `BLINK_BIT_OFFSET;
      if (code == 3'h0 || code > `BLINK_CODE_MAX)
         blink_phase = 1'b1;
      else
         blink_phase = ~cnt[pos];
   endfunction

   ////////////////////////////////////////////////////////////////
   // Access decode
   wire logic released = mpd_reg[`MPD_HOST_RELEASE] & ~pd_sync_reg;
   wire logic wr_ok = io_wr & ~released;
   wire logic rd_ok = io_rd & ~released;
   wire logic map_open = (map_key_reg == `MAP_KEY_VALUE);
   wire logic wr_pc2 = wr_ok & panel_open_reg & (io_index == `IDX_PANEL_CONTROL_TWO);
   wire logic wr_pkey = wr_ok & (io_index == `IDX_PANEL_UNLOCK_KEY);
   wire logic wr_mkey = wr_ok & (io_index == `IDX_MAP_UNLOCK_KEY);
   wire logic wr_addr = wr_ok & map_open & (io_index == `IDX_MAP_ADDR_COUNTER);
   wire logic wr_data = wr_ok & map_open & (io_index == `IDX_MAP_DATA_PORT);
   wire logic rd_data = rd_ok & map_open & (io_index == `IDX_MAP_DATA_PORT);
   wire logic wr_mpd = wr_ok & map_open & (io_index == `IDX_MAP_PD_CONTROL);
   wire logic wr_height = wr_ok & panel_open_reg & (io_index == `IDX_PANEL_HEIGHT);
   wire logic wr_blink = wr_ok & panel_open_reg & (io_index == `IDX_PANEL_BLINK);
   wire logic wr_clc = wr_ok & panel_open_reg & (io_index == `IDX_COLOR_LCD);
   wire logic wr_pdr = wr_ok & panel_open_reg & (io_index == `IDX_PD_REFRESH);
   wire logic gen_pd = pdr_reg[`PDR_GENERAL_PD];

   // Read mux; locked or unmapped indices read zero
   fp_regs_pkg::byte_t rd_mux;
   always_comb
   begin
      rd_mux = `RST_BYTE;
      if (panel_open_reg)
      begin
         unique case (io_index)
            `IDX_PANEL_CONTROL_TWO: rd_mux = pc2_reg;
            `IDX_PANEL_HEIGHT: rd_mux = height_reg;
            `IDX_PANEL_BLINK: rd_mux = blink_reg;
            `IDX_COLOR_LCD: rd_mux = clc_reg;
            `IDX_PD_REFRESH: rd_mux = pdr_reg;
            default: rd_mux = `RST_BYTE;
         endcase
      end
      if (io_index == `IDX_MAP_UNLOCK_KEY)
         rd_mux = map_key_reg;
      if (map_open)
      begin
         unique case (io_index)
            `IDX_MAP_ADDR_COUNTER: rd_mux = map_addr_reg;
            `IDX_MAP_DATA_PORT: rd_mux = map_ram[map_addr_reg];
            `IDX_MAP_PD_CONTROL: rd_mux = mpd_reg;
            default: rd_mux = rd_mux;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Powerdown pin synchroniser
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         pd_meta_reg <= 1'b0;
         pd_sync_reg <= 1'b0;
      end
      else
      begin
         pd_meta_reg <= powerdown_input;
         pd_sync_reg <= pd_meta_reg;
      end
   end

   // Unlock keys; any other value relocks
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         panel_open_reg <= 1'b0;
         shadow_open_reg <= 1'b0;
         map_key_reg <= `RST_BYTE;
      end
      else
      begin
         if (wr_pkey)
         begin
            panel_open_reg <= (io_wdata[6:4] == `PANEL_KEY_PATTERN);
            shadow_open_reg <= (io_wdata[2:0] == `SHADOW_KEY_PATTERN);
         end
         if (wr_mkey)
            map_key_reg <= io_wdata;
      end
   end

   // Protected control registers
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         pc2_reg <= `RST_BYTE;
         mpd_reg <= `RST_BYTE;
         height_reg <= `RST_BYTE;
         blink_reg <= `RST_BYTE;
         clc_reg <= `RST_BYTE;
         pdr_reg <= `RST_BYTE;
      end
      else
      begin
         if (wr_pc2)
            pc2_reg <= io_wdata;
         if (wr_mpd)
            mpd_reg <= io_wdata & `MPD_WRITE_MASK;
         if (wr_height)
            height_reg <= io_wdata;
         if (wr_blink)
            blink_reg <= io_wdata;
         if (wr_clc)
            clc_reg <= io_wdata;
         if (wr_pdr)
            pdr_reg <= io_wdata;
      end
   end

   // Mapping RAM address counter, post-increment with wrap
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         map_addr_reg <= `RST_BYTE;
      else if (wr_addr)
         map_addr_reg <= io_wdata;
      else if (wr_data | rd_data)
         map_addr_reg <= map_addr_reg + 8'h01;
   end

   // Mapping RAM write port
   always_ff @(posedge ref_clk)
   begin
      if (wr_data)
         map_ram[map_addr_reg] <= io_wdata;
   end

   // Host read data and bus drive
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         io_rdata <= `RST_BYTE;
         io_rdata_oe <= 1'b0;
         sys_bus_oe <= 1'b1;
      end
      else
      begin
         io_rdata <= rd_ok ? rd_mux : `RST_BYTE;
         io_rdata_oe <= rd_ok;
         sys_bus_oe <= ~released;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Divide-by-8 tick for general powerdown
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         div_cnt_reg <= 3'h0;
         pd_div8_tick <= 1'b0;
      end
      else if (gen_pd & mpd_reg[`MPD_DIV8])
      begin
         div_cnt_reg <= div_cnt_reg + 3'h1;
         pd_div8_tick <= (div_cnt_reg == `PD_DIV_RATIO);
      end
      else
      begin
         div_cnt_reg <= 3'h0;
         pd_div8_tick <= 1'b0;
      end
   end

   // Frame counter for blink phases
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         frame_cnt_reg <= `RST_BYTE;
      else if (frame_tick)
         frame_cnt_reg <= frame_cnt_reg + 8'h01;
   end

   // Registered control outputs
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         shading_pwm <= 1'b0;
         refresh_by_count <= 1'b0;
         refresh_two_per_line <= 1'b0;
         panel_unlocked <= 1'b0;
         shadow_unlocked <= 1'b0;
         sys_powerdown_mode <= 1'b0;
         clocks_stopped <= 1'b0;
         mapping_bypass <= 1'b0;
         weighting_enable <= 1'b0;
         panel_height <= `RST_BYTE;
         shift_clk_polarity <= 1'b0;
         char_blink_on <= 1'b1;
         cursor_blink_on <= 1'b1;
         shade_value <= `RST_BYTE;
      end
      else
      begin
         shading_pwm <= pc2_reg[`PC2_SHADING];
         refresh_by_count <= pc2_reg[`PC2_REFRESH_SRC];
         refresh_two_per_line <= pc2_reg[`PC2_REFRESH_SRC] & pc2_reg[`PC2_REFRESH_TWO];
         panel_unlocked <= panel_open_reg;
         shadow_unlocked <= shadow_open_reg;
         sys_powerdown_mode <= mpd_reg[`MPD_SYS_POWERDOWN];
         clocks_stopped <= gen_pd & mpd_reg[`MPD_SYS_POWERDOWN];
         mapping_bypass <= mpd_reg[`MPD_MAP_BYPASS];
         weighting_enable <= mpd_reg[`MPD_WEIGHTING];
         panel_height <= height_reg;
         shift_clk_polarity <= blink_reg[`BLK_SCLK_POL];
         char_blink_on <= crt_mode | blink_phase(blink_reg[5:3], frame_cnt_reg);
         cursor_blink_on <= crt_mode | blink_phase(blink_reg[2:0], frame_cnt_reg);
         shade_value <= mpd_reg[`MPD_MAP_BYPASS] ? shade_index : map_ram[shade_index];
      end
   end

   // Panel and CRT pin shaping
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         line_latch_pulse <= 1'b0;
         frame_start_pulse <= 1'b0;
         shift_clk_stop <= 1'b0;
         vsync_out <= 1'b1;
         hsync_out <= 1'b1;
      end
      else
      begin
         line_latch_pulse <= (line_latch_raw & (~vblank | blink_reg[`BLK_LP_FREE_RUN]))
                             ^ clc_reg[`CLC_LP_POL];
         shift_clk_stop <= vblank & blink_reg[`BLK_LP_FREE_RUN];
         frame_start_pulse <= frame_start_raw ^ clc_reg[`CLC_FP_POL];
         vsync_out <= clc_reg[`CLC_CRT_SYNC] ? crt_vsync : 1'b1;
         hsync_out <= clc_reg[`CLC_CRT_SYNC] ? crt_hsync : 1'b1;
      end
   end
endmodule // flat_panel_control_regs
`default_nettype wire

/* File: fp_regs_chk.sv */
// Assertion checker for the flat panel control register bank
`timescale 1ns/1ps
`default_nettype none
module fp_regs_chk
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Host port
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_index,
   input wire logic [7:0] io_wdata,
   input wire logic io_rdata_oe,
   input wire logic sys_bus_oe,
   // Fields and pins
   input wire logic vblank,
   input wire logic crt_vsync,
   input wire logic crt_mode,
   input wire logic [7:0] shade_index,
   input wire logic [7:0] shade_value,
   input wire logic shadow_unlocked,
   input wire logic sys_powerdown_mode,
   input wire logic clocks_stopped,
   input wire logic pd_div8_tick,
   input wire logic mapping_bypass,
   input wire logic shift_clk_stop,
   input wire logic char_blink_on,
   input wire logic vsync_out
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Accepted write to the unlock key
   wire key_wr = io_wr && sys_bus_oe && io_index == 8'h34;
   ////////////////////////////////////////
   // Read answer follows the same release state that drives the bus enable
   property p_rd; io_rd |=> io_rdata_oe == sys_bus_oe; endproperty
   a_rd: assert property (p_rd) else $error("read answer disagrees with bus drive");
   property p_rel; !io_rd |=> !io_rdata_oe; endproperty
   a_rel: assert property (p_rel) else $error("read answered without request");
   property p_shd; key_wr |-> ##2 shadow_unlocked == ($past(io_wdata[2:0], 2) == 3'h6); endproperty
   a_shd: assert property (p_shd) else $error("shadow lock wrong");
   property p_byp; mapping_bypass |-> shade_value == $past(shade_index); endproperty
   a_byp: assert property (p_byp) else $error("bypass not direct");
   property p_clk; clocks_stopped |-> sys_powerdown_mode; endproperty
   a_clk: assert property (p_clk) else $error("clocks stopped in idle mode");
   property p_div; pd_div8_tick |=> !pd_div8_tick [*7]; endproperty
   a_div: assert property (p_div) else $error("divide tick too early");
   property p_crt; crt_mode [*2] |-> char_blink_on; endproperty
   a_crt: assert property (p_crt) else $error("blink in crt mode");
   property p_stp; shift_clk_stop |-> $past(vblank); endproperty
   a_stp: assert property (p_stp) else $error("shift stop outside vblank");
   property p_vs; crt_vsync |=> vsync_out; endproperty
   a_vs: assert property (p_vs) else $error("vsync low without cause");
   // Main scenarios
   c_shd: cover property (shadow_unlocked);
   c_div: cover property (pd_div8_tick);
   c_rel: cover property (!sys_bus_oe);
endmodule // fp_regs_chk
bind flat_panel_control_regs fp_regs_chk chk (.ref_clk, .rst, .io_wr, .io_rd, .io_index, .io_wdata,
   .io_rdata_oe, .sys_bus_oe, .vblank, .crt_vsync, .crt_mode, .shade_index, .shade_value, .shadow_unlocked,
   .sys_powerdown_mode, .clocks_stopped, .pd_div8_tick, .mapping_bypass, .shift_clk_stop, .char_blink_on,
   .vsync_out);
`default_nettype wire

/* File: fp_host_model.sv */
// Host CPU model driving the indexed register port
`timescale 1ns/1ps
`default_nettype none
module fp_host_model
(
   // Clock
   input wire logic ref_clk,
   // Indexed port
   output logic io_wr = 1'b0,
   output logic io_rd = 1'b0,
   output logic [7:0] io_index = 8'h00,
   output logic [7:0] io_wdata = 8'h00,
   input wire logic [7:0] io_rdata
);
   // Byte-wide write, strobe for one clock
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      @(negedge ref_clk);
      io_index = idx;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge ref_clk);
      io_wr = 1'b0;
      io_wdata = ~d;
   endtask
   // Byte-wide read, data taken one edge later
   task automatic rd(input logic [7:0] idx, output logic [7:0] d);
      @(negedge ref_clk);
      io_index = idx;
      io_rd = 1'b1;
      @(negedge ref_clk);
      io_rd = 1'b0;
      d = io_rdata;
   endtask
endmodule // fp_host_model
`default_nettype wire

/* File: tb_top.sv */
// Self-checking testbench for the flat panel control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic ref_clk = 1'b0, rst = 1'b1, powerdown_input = 1'b1, frame_tick = 1'b0, crt_mode = 1'b0, vblank = 1'b0;
   logic crt_vsync = 1'b1, crt_hsync = 1'b1, frame_start_raw = 1'b0, line_latch_raw = 1'b0;
   logic [7:0] shade_index = 8'h00, io_rdata, shade_value, panel_height, d;
   logic io_rdata_oe, sys_bus_oe, shading_pwm, refresh_by_count, refresh_two_per_line, panel_unlocked;
   logic shadow_unlocked, sys_powerdown_mode, clocks_stopped, pd_div8_tick, mapping_bypass, weighting_enable;
   logic shift_clk_polarity, shift_clk_stop, char_blink_on, cursor_blink_on, line_latch_pulse, frame_start_pulse;
   logic vsync_out, hsync_out, pc, pu;
   wire io_wr, io_rd;
   wire [7:0] io_index, io_wdata;
   logic [7:0] ctl2 [4] = '{8'h07, 8'h01, 8'h02, 8'h04};
   int error_cnt = 0, checks_done = 0, cycles = 0, n, m;
   flat_panel_control_regs dut (.*);
   fp_host_model host (.*);
   always #25 ref_clk = ~ref_clk;
   ////////////////////////////////////////
   // Compare and report
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Write, then let the output fields settle
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      host.wr(idx, v);
      @(negedge ref_clk);
   endtask
   task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input string nm);
      host.rd(idx, d);
      chk(nm, d, exp);
   endtask
   // Frame ticks, counting blink output changes
   task automatic frames(input int k);
      n = 0;
      m = 0;
      repeat (k)
      begin
         pc = char_blink_on;
         pu = cursor_blink_on;
         frame_tick = 1'b1;
         @(negedge ref_clk);
         frame_tick = 1'b0;
         @(negedge ref_clk);
         n += int'(pc !== char_blink_on);
         m += int'(pu !== cursor_blink_on);
      end
   endtask
   // Count divide-by-8 ticks over k cycles
   task automatic ticks(input int k);
      n = 0;
      repeat (k)
      begin
         @(negedge ref_clk);
         n += int'(pd_div8_tick === 1'b1);
      end
   endtask
   task automatic results;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Hang guard
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         error_cnt++;
         results;
      end
   end
   ////////////////////////////////////////
   initial
   begin
      repeat (3) @(negedge ref_clk);
      rst = 1'b0;
      chk("vsync_idle", vsync_out, 8'h01);
      chk("hsync_idle", hsync_out, 8'h01);
      wr(8'h3B, 8'hEF);
      wr(8'h34, 8'h56);
      rdchk(8'h3B, 8'h00, "height_locked");
      chk("shadow_open", shadow_unlocked, 8'h01);
      wr(8'h3B, 8'hEF);
      chk("height", panel_height, 8'hEF);
      wr(8'h34, 8'h06);
      chk("panel_closed", panel_unlocked, 8'h00);
      wr(8'h3B, 8'h11);
      wr(8'h34, 8'h50);
      chk("shadow_closed", shadow_unlocked, 8'h00);
      rdchk(8'h3B, 8'hEF, "height_kept");
      foreach (ctl2[i])
      begin
         wr(8'h33, ctl2[i]);
         chk("shading", shading_pwm, {7'h00, ctl2[i][2]});
         chk("by_count", refresh_by_count, {7'h00, ctl2[i][0]});
         chk("two_per_line", refresh_two_per_line, {7'h00, &ctl2[i][1:0]});
      end
      // Mapping RAM through the counter
      wr(8'h38, 8'h05);
      wr(8'h35, 8'h30);
      rdchk(8'h38, 8'h00, "ctr_locked");
      wr(8'h38, 8'hFE);
      wr(8'h39, 8'hAA);
      wr(8'h39, 8'hBB);
      rdchk(8'h38, 8'h00, "ctr_wrap");
      wr(8'h38, 8'hFE);
      rdchk(8'h39, 8'hAA, "ram_fe");
      rdchk(8'h39, 8'hBB, "ram_ff");
      rdchk(8'h38, 8'h00, "ctr_reads");
      shade_index = 8'hFF;
      @(negedge ref_clk);
      chk("ram_map", shade_value, 8'hBB);
      wr(8'h3A, 8'hFF);
      chk("weight", weighting_enable, 8'h01);
      chk("bypass", shade_value, 8'hFF);
      chk("bypass_bit", mapping_bypass, 8'h01);
      chk("sys_pd", sys_powerdown_mode, 8'h01);
      chk("idle_clk", clocks_stopped, 8'h00);
      ticks(16);
      chk("div8_off", n[7:0], 8'h00);
      rdchk(8'h3A, 8'hEA, "mpd");
      wr(8'h3F, 8'h80);
      chk("clk_stop", clocks_stopped, 8'h01);
      ticks(64);
      chk("div8", n[7:0], 8'h08);
      // Host release
      powerdown_input = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk("released", sys_bus_oe, 8'h00);
      rdchk(8'h3A, 8'h00, "rel_read");
      wr(8'h3A, 8'h00);
      powerdown_input = 1'b1;
      repeat (4) @(negedge ref_clk);
      rdchk(8'h3A, 8'hEA, "rel_kept");
      wr(8'h35, 8'h31);
      rdchk(8'h3A, 8'h00, "map_locked");
      // Blink codes
      for (int c = 0; c < 6; c++)
      begin
         wr(8'h3C, {2'b00, c[2:0], c[2:0]});
         frames(256);
         chk("char_blink", n[7:0], (c == 0) ? 8'h00 : 8'(256 >> (c + 2)));
         chk("cursor_blink", m[7:0], (c == 0) ? 8'h00 : 8'(256 >> (c + 2)));
      end
      crt_mode = 1'b1;
      wr(8'h3C, 8'h09);
      frames(32);
      chk("crt_blink", n[7:0], 8'h00);
      chk("crt_cursor", m[7:0], 8'h00);
      wr(8'h3C, 8'h40);
      chk("sclk_pol", shift_clk_polarity, 8'h01);
      vblank = 1'b1;
      line_latch_raw = 1'b1;
      wr(8'h3C, 8'h40);
      chk("lp_vblank", line_latch_pulse, 8'h00);
      wr(8'h3C, 8'hC0);
      chk("lp_free", line_latch_pulse, 8'h01);
      chk("shift_stop", shift_clk_stop, 8'h01);
      crt_vsync = 1'b0;
      crt_hsync = 1'b0;
      frame_start_raw = 1'b1;
      wr(8'h3E, 8'h02);
      chk("vsync_held", vsync_out, 8'h01);
      chk("hsync_held", hsync_out, 8'h01);
      chk("fp_inv", frame_start_pulse, 8'h00);
      wr(8'h3E, 8'h04);
      chk("vsync_pass", vsync_out, 8'h00);
      chk("hsync_pass", hsync_out, 8'h00);
      chk("fp_norm", frame_start_pulse, 8'h01);
      results;
   end
endmodule // tb_top
`default_nettype wire
